// ==== hw/rxwp_pkg.sv ====
// rxwp_pkg: constants, modes and carrier struct for the receive word packer.
// assumes one 50 MHz clock domain; shared by the packer top and its lane module.
package rxwp_pkg;

    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned HALF_W = 16;

    // wide word field positions, lower half (upper half is +HALF_W)
    localparam int unsigned POS_DATA = 0;
    localparam int unsigned POS_CTRL = 8;
    localparam int unsigned POS_ERR = 9;
    localparam int unsigned POS_SYNC = 10;
    localparam int unsigned POS_DISPERR = 11;
    localparam int unsigned POS_PATTERN = 12;
    localparam int unsigned POS_RMDEL = 13;
    localparam int unsigned POS_RMINS = 14;
    localparam int unsigned POS_RDISP = 15;

    // register indices on the plain register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_IRQ_STAT = 4'h2;
    localparam logic [3:0] REG_IRQ_MASK = 4'h3;
    localparam logic [3:0] REG_RECFG = 4'h4;

    // control and reconfiguration register field positions
    localparam int unsigned CTRL_WIDTH_LSB = 0;
    localparam int unsigned CTRL_PIPE_BIT = 2;
    localparam int unsigned CTRL_DIV2_BIT = 3;
    localparam int unsigned CTRL_CLKSEL_LSB = 4;
    localparam int unsigned RECFG_MODE_LSB = 0;
    localparam int unsigned RECFG_START_BIT = 8;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam logic [5:0] RECFG_ADDR_LAST = 6'h3f;

    // interrupt status bit positions
    localparam int unsigned IRQ_ERR = 0;
    localparam int unsigned IRQ_DISPERR = 1;
    localparam int unsigned IRQ_SYNC_LOST = 2;
    localparam int unsigned IRQ_RECFG_DONE = 3;

    typedef enum logic [1:0] {
        RXWP_W8,
        RXWP_W10,
        RXWP_W16,
        RXWP_W20
    } rxwp_width_e;

    typedef enum logic [1:0] {
        RXWP_CLK_SHARED_TX,
        RXWP_CLK_OWN_TX,
        RXWP_CLK_OWN_RX,
        RXWP_CLK_RSVD
    } rxwp_clksel_e;

    // one received symbol with its per-symbol status
    typedef struct packed {
        logic [9:0] sym;
        logic ctrl;
        logic err;
        logic sync;
        logic disperr;
        logic pattern;
        logic rm_del;
        logic rm_ins;
        logic [1:0] pipe_status;
        logic rdisp;
    } rxwp_lane_s;

endpackage : rxwp_pkg

// ==== hw/rxwp_lane.sv ====
// rxwp_lane: packs one symbol and its status flags into a 16-bit half word.
// assumes the caller registers the result; purely combinational.
`timescale 1ns/1ns
`default_nettype none
module rxwp_lane (
    input wire rxwp_pkg::rxwp_lane_s LANE,  // symbol and flags
    input wire logic CODED,                 // 8-bit decoded symbol in use
    input wire logic PIPE,                  // pipe mode selects status field
    output logic [15:0] HALF                // packed half word
);
    import rxwp_pkg::*;

    always_comb begin
        HALF = 16'h0000;
        if (CODED) begin
            HALF[POS_DATA +: 8] = LANE.sym[7:0];
            HALF[POS_CTRL] = LANE.ctrl;
            HALF[POS_ERR] = LANE.err;
        end else begin
            // raw symbol covers the control and error positions
            HALF[POS_DATA +: 10] = LANE.sym;
        end
        HALF[POS_SYNC] = LANE.sync;
        HALF[POS_DISPERR] = LANE.disperr;
        HALF[POS_PATTERN] = LANE.pattern;
        if (PIPE) begin
            HALF[POS_RMDEL +: 2] = LANE.pipe_status;
        end else begin
            HALF[POS_RMDEL] = LANE.rm_del;
            HALF[POS_RMINS] = LANE.rm_ins;
        end
        HALF[POS_RDISP] = LANE.rdisp;
    end

endmodule // rxwp_lane
`default_nettype wire

// ==== hw/rxwp_top.sv ====
// rxwp_top: receive word packer toward fabric, with rate divider, clock select
// and reconfiguration handshake. assumes lane inputs are on CLK's domain.
//
// Behaviour
// - 8-bit coded: data byte at [7:0], control flag at bit 8.
// - 8-bit coded: code violation at bit 9, sync status at bit 10.
// - 8-bit: disparity error at bit 11, pattern detect at bit 12.
// - non-pipe: rate-match deletion at bit 13, insertion at bit 14.
// - pipe mode: bits 14:13 carry the 2-bit pipe status.
// - running disparity appears at bit 15.
// - 10-bit: raw symbol at [9:0], bits 10-15 keep their meanings.
// - 16-bit: lower byte at [7:0], upper byte at [23:16].
// - 16-bit: upper byte flags at 24-28, sixteen above the lower.
// - 16-bit pipe: status at 14:13 and 30:29.
// - 20-bit: lower symbol at [9:0], upper at [25:16].
// - wide modes: upper deletion, insertion, disparity at 29, 30, 31.
// - receive path offers divide-by-two rate option; no transmit equivalent.
// - 3-bit mode select, 6-bit address, valid, done and busy out.
// - read clock chosen from shared tx, own tx or own rx clock.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module rxwp_top #(
    parameter int unsigned RECFG_WORDS = 64  // words written per reconfiguration
) (
    input wire logic CLK,                        // 50 MHz clock
    input wire logic RST_N,                      // async reset, active low
    input wire rxwp_pkg::rxwp_lane_s LANE_LO,    // lower symbol and flags
    input wire rxwp_pkg::rxwp_lane_s LANE_HI,    // upper symbol and flags
    input wire logic LANE_VALID,                 // lane inputs carry a symbol
    input wire logic CLK_SHARED_TX_EN,           // shared tx core clock tick
    input wire logic CLK_OWN_TX_EN,              // own tx core clock tick
    input wire logic CLK_OWN_RX_EN,              // own rx core clock tick
    output logic [31:0] RX_WORD,                 // packed wide receive word
    output logic RX_WORD_VALID,                  // RX_WORD updated this cycle
    input wire logic [3:0] REG_ADDR,             // register index
    input wire logic [31:0] REG_WDATA,           // register write data
    input wire logic REG_WR,                     // write strobe
    input wire logic REG_RD,                     // read strobe
    output logic [31:0] REG_RDATA,               // read data, one cycle later
    output logic IRQ,                            // level interrupt
    output logic [2:0] RECFG_MODE_SEL,           // reconfiguration mode select
    output logic [5:0] RECFG_ADDR_OUT,           // reconfiguration word address
    output logic RECFG_ADDR_EN,                  // address valid strobe
    output logic RECFG_DONE,                     // reconfiguration done
    output logic RECFG_BUSY                      // reconfiguration in progress
);
    import rxwp_pkg::*;

    typedef enum {
        RXWP_IDLE,
        RXWP_WRITE,
        RXWP_FINISH
    } rxwp_state_e;

    logic [31:0] ctrl;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [2:0] mode_sel;
    logic div_phase;
    logic read_tick;
    logic take;
    logic [15:0] half_lo;
    logic [15:0] half_hi;
    logic [31:0] next_word;
    logic [3:0] events;
    logic sync_prev;
    logic [6:0] word_cnt;
    logic recfg_start;
    rxwp_state_e state;
    rxwp_width_e width;
    rxwp_clksel_e clksel;
    logic pipe;
    logic div2;
    logic wide;
    logic coded;

    assign width = rxwp_width_e'(ctrl[CTRL_WIDTH_LSB +: 2]);
    assign pipe = ctrl[CTRL_PIPE_BIT];
    assign div2 = ctrl[CTRL_DIV2_BIT];
    assign clksel = rxwp_clksel_e'(ctrl[CTRL_CLKSEL_LSB +: 2]);
    assign wide = (width == RXWP_W16) || (width == RXWP_W20);
    assign coded = (width == RXWP_W8) || (width == RXWP_W16);
    assign recfg_start = REG_WR && (REG_ADDR == REG_RECFG) && REG_WDATA[RECFG_START_BIT];

    // read-clock source select; the reserved code falls back to the own rx clock
    always_comb begin
        case (clksel)
            RXWP_CLK_SHARED_TX: read_tick = CLK_SHARED_TX_EN;
            RXWP_CLK_OWN_TX: read_tick = CLK_OWN_TX_EN;
            RXWP_CLK_OWN_RX: read_tick = CLK_OWN_RX_EN;
            default: read_tick = CLK_OWN_RX_EN;
        endcase
    end

    // halving the rate drops every second symbol rather than needing another pll
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_phase <= 1'b0;
        end else if (!div2) begin
            div_phase <= 1'b0;
        end else if (read_tick && LANE_VALID) begin
            div_phase <= ~div_phase;
        end
    end

    assign take = read_tick && LANE_VALID && (!div2 || !div_phase);

    rxwp_lane u_lane_lo (
        .LANE(LANE_LO),
        .CODED(coded),
        .PIPE(pipe),
        .HALF(half_lo)
    );

    rxwp_lane u_lane_hi (
        .LANE(LANE_HI),
        .CODED(coded),
        .PIPE(pipe),
        .HALF(half_hi)
    );

    // narrow modes leave the upper half zero
    assign next_word = {(wide ? half_hi : 16'h0000), half_lo};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RX_WORD <= 32'h0000_0000;
        end else if (take) begin
            RX_WORD <= next_word;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RX_WORD_VALID <= 1'b0;
        end else begin
            RX_WORD_VALID <= take;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync_prev <= 1'b0;
        end else if (take) begin
            sync_prev <= LANE_LO.sync;
        end
    end

    always_comb begin
        events = 4'h0;
        events[IRQ_ERR] = take && coded && (LANE_LO.err || (wide && LANE_HI.err));
        events[IRQ_DISPERR] = take && (LANE_LO.disperr || (wide && LANE_HI.disperr));
        events[IRQ_SYNC_LOST] = take && sync_prev && !LANE_LO.sync;
        events[IRQ_RECFG_DONE] = (state == RXWP_FINISH);
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl <= CTRL_RESET;
        end else if (REG_WR && (REG_ADDR == REG_CTRL)) begin
            ctrl <= REG_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_mask <= IRQ_MASK_RESET;
        end else if (REG_WR && (REG_ADDR == REG_IRQ_MASK)) begin
            irq_mask <= REG_WDATA[3:0];
        end
    end

    // a read clears, but an event in the same cycle survives
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat <= 4'h0;
        end else if (REG_RD && (REG_ADDR == REG_IRQ_STAT)) begin
            irq_stat <= events;
        end else begin
            irq_stat <= irq_stat | events;
        end
    end

    assign IRQ = |(irq_stat & irq_mask);

    // mode select is latched only while idle so a running pass stays consistent
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_sel <= 3'h0;
        end else if (recfg_start && (state == RXWP_IDLE)) begin
            mode_sel <= REG_WDATA[RECFG_MODE_LSB +: 3];
        end
    end

    assign RECFG_MODE_SEL = mode_sel;

    // walk the word addresses; a start outside the idle state is ignored
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= RXWP_IDLE;
            word_cnt <= 7'h00;
        end else begin
            case (state)
                RXWP_IDLE: begin
                    word_cnt <= 7'h00;
                    if (recfg_start) begin
                        state <= RXWP_WRITE;
                    end
                end
                RXWP_WRITE: begin
                    if (word_cnt == 7'(RECFG_WORDS - 1)) begin
                        state <= RXWP_FINISH;
                    end else begin
                        word_cnt <= word_cnt + 7'h01;
                    end
                end
                RXWP_FINISH: state <= RXWP_IDLE;
                default: state <= RXWP_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RECFG_ADDR_OUT <= 6'h00;
            RECFG_ADDR_EN <= 1'b0;
            RECFG_BUSY <= 1'b0;
        end else begin
            RECFG_ADDR_OUT <= word_cnt[5:0] & RECFG_ADDR_LAST;
            RECFG_ADDR_EN <= (state == RXWP_WRITE);
            RECFG_BUSY <= (state != RXWP_IDLE) || recfg_start;
        end
    end

    // done holds until the next start; it rises on the edge at which busy falls,
    // the only cycle in which busy is still high while the walk is idle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RECFG_DONE <= 1'b0;
        end else if (recfg_start && (state == RXWP_IDLE)) begin
            RECFG_DONE <= 1'b0;
        end else if (RECFG_BUSY && (state == RXWP_IDLE)) begin
            RECFG_DONE <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                REG_CTRL: REG_RDATA <= ctrl;
                REG_STATUS: REG_RDATA <= {24'h000000, RECFG_ADDR_OUT, RECFG_DONE, RECFG_BUSY};
                REG_IRQ_STAT: REG_RDATA <= {28'h0000000, irq_stat};
                REG_IRQ_MASK: REG_RDATA <= {28'h0000000, irq_mask};
                REG_RECFG: REG_RDATA <= {29'h00000000, mode_sel};
                default: REG_RDATA <= 32'h0000_0000;
            endcase
        end else begin
            REG_RDATA <= 32'h0000_0000;
        end
    end

endmodule // rxwp_top
`default_nettype wire

// ==== verification/rxwp_chk.sv ====
// rxwp_chk: port-level checks on the receive word packer.
// assumes one clock domain; bound into every rxwp_top.
`timescale 1ns/1ns
`default_nettype none
module rxwp_chk import rxwp_pkg::*; #(
    parameter int unsigned RECFG_WORDS = 64  // words per reconfiguration
) (
    input wire logic CLK,  // clock
    input wire logic RST_N,  // async reset
    input wire logic [3:0] REG_ADDR,  // register index
    input wire logic [31:0] REG_WDATA,  // write data
    input wire logic REG_WR,  // write strobe
    input wire logic REG_RD,  // read strobe
    input wire logic [31:0] REG_RDATA,  // read data
    input wire logic [31:0] RX_WORD,  // packed word
    input wire logic RX_WORD_VALID,  // new word
    input wire logic IRQ,  // interrupt
    input wire logic [2:0] RECFG_MODE_SEL,  // mode
    input wire logic [5:0] RECFG_ADDR_OUT,  // address
    input wire logic RECFG_ADDR_EN,  // address valid
    input wire logic RECFG_DONE,  // done
    input wire logic RECFG_BUSY  // busy
);
    logic [7:0] run_len;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // length of the current address burst, compared when it ends
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            run_len <= 8'h00;
        end else begin
            run_len <= RECFG_ADDR_EN ? run_len + 8'h01 : 8'h00;
        end
    end
    AST_WORD_HOLD: assert property (!RX_WORD_VALID |-> $stable(RX_WORD))
        else $error("word changed without valid");
    AST_RDATA_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
        else $error("read data outside its cycle");
    AST_UNMAPPED: assert property (REG_RD && REG_ADDR > 4'h4 |=> REG_RDATA == 32'h0)
        else $error("unmapped read not zero");
    AST_START: assert property (REG_WR && REG_ADDR == REG_RECFG && REG_WDATA[8]
        && !RECFG_BUSY |=> RECFG_BUSY && !RECFG_DONE
        && RECFG_MODE_SEL == $past(REG_WDATA[2:0]))
        else $error("reconfig start wrong");
    AST_MODE_HOLD: assert property (RECFG_BUSY && $past(RECFG_BUSY)
        |-> $stable(RECFG_MODE_SEL))
        else $error("mode changed while busy");
    AST_EN_BUSY: assert property (RECFG_ADDR_EN |-> RECFG_BUSY && !RECFG_DONE)
        else $error("address strobe outside busy");
    AST_FIRST_ADDR: assert property ($rose(RECFG_BUSY) |-> ##1
        (RECFG_ADDR_EN && RECFG_ADDR_OUT == 6'h00))
        else $error("first address wrong");
    AST_ADDR_STEP: assert property (RECFG_ADDR_EN && $past(RECFG_ADDR_EN)
        |-> RECFG_ADDR_OUT == $past(RECFG_ADDR_OUT) + 6'h01)
        else $error("address did not step");
    AST_RUN_LEN: assert property ($fell(RECFG_ADDR_EN) |-> run_len == RECFG_WORDS
        ##1 (RECFG_DONE && !RECFG_BUSY))
        else $error("burst length or end wrong");
    AST_DONE_BUSY: assert property (RECFG_DONE |-> !RECFG_BUSY)
        else $error("done while busy");
    cover property (RX_WORD_VALID && RX_WORD[31:16] != 16'h0);
    cover property ($rose(RECFG_DONE));
    cover property ($rose(IRQ));
endmodule // rxwp_chk
bind rxwp_top rxwp_chk #(.RECFG_WORDS(RECFG_WORDS)) chk (.CLK(CLK), .RST_N(RST_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .RX_WORD(RX_WORD), .RX_WORD_VALID(RX_WORD_VALID), .IRQ(IRQ),
    .RECFG_MODE_SEL(RECFG_MODE_SEL), .RECFG_ADDR_OUT(RECFG_ADDR_OUT),
    .RECFG_ADDR_EN(RECFG_ADDR_EN), .RECFG_DONE(RECFG_DONE), .RECFG_BUSY(RECFG_BUSY));
`default_nettype wire

// ==== verification/rxwp_fabric.sv ====
// rxwp_fabric: fabric-side core clock ticks for the receive read side.
// assumes ticks are enables on the one system clock.
`timescale 1ns/1ns
`default_nettype none
module rxwp_fabric (
    input wire logic clk,  // clock
    input wire logic rst_n,  // async reset
    input wire logic slow,  // sparse ticks
    output logic shared_tx,  // shared tx core clock tick
    output logic own_tx,  // own tx core clock tick
    output logic own_rx  // own rx core clock tick
);
    logic [2:0] cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'h0;
        end else begin
            cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
        end
    end
    assign shared_tx = !slow || cnt[0];
    assign own_tx = cnt[0];  // fabric tx clock at half rate, whatever slow is
    assign own_rx = !slow || cnt == 3'h0;
endmodule // rxwp_fabric
`default_nettype wire

// ==== verification/rxwp_top_test.sv ====
// rxwp_top_test: random lanes in every width, pipe, div2 and clock choice.
// assumes rxwp_chk is bound to the design; short reconfiguration bursts.
`timescale 1ns/1ns
`default_nettype none
module rxwp_top_test;
    import rxwp_pkg::*;
    localparam int unsigned NW = 4;
    logic clk = 1'b0, rst_n = 1'b0, lane_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic slow = 1'b0, phase = 1'b0, go = 1'b0, rd_p = 1'b0;
    rxwp_lane_s lane_lo = '0, lane_hi = '0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, st = 32'd62, ctl = 32'h0, rx_word, rdata;
    logic t_sh, t_tx, t_rx, vld, irq, aen, done, busy;
    logic [2:0] msel;
    logic [5:0] aout;
    logic [63:0] wq[$], rq[$];
    int n_fail = 0, tests_run = 0;
    always #10 clk = ~clk;
    rxwp_fabric fab (.clk(clk), .rst_n(rst_n), .slow(slow), .shared_tx(t_sh),
        .own_tx(t_tx), .own_rx(t_rx));
    rxwp_top #(.RECFG_WORDS(NW)) dut (.CLK(clk), .RST_N(rst_n), .LANE_LO(lane_lo),
        .LANE_HI(lane_hi), .LANE_VALID(lane_valid), .CLK_SHARED_TX_EN(t_sh),
        .CLK_OWN_TX_EN(t_tx), .CLK_OWN_RX_EN(t_rx), .RX_WORD(rx_word),
        .RX_WORD_VALID(vld), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .IRQ(irq),
        .RECFG_MODE_SEL(msel), .RECFG_ADDR_OUT(aout), .RECFG_ADDR_EN(aen),
        .RECFG_DONE(done), .RECFG_BUSY(busy));
    function automatic logic [15:0] half(rxwp_lane_s l, logic cd, logic pp);
        logic [15:0] h;
        h = {l.rdisp, pp ? l.pipe_status : {l.rm_ins, l.rm_del}, l.pattern,
            l.disperr, l.sync, l.sym};
        if (cd) h[9:8] = {l.err, l.ctrl};
        return h;
    endfunction
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(logic [31:0] got, logic [63:0] e);
        tests_run++;
        if ((got & e[63:32]) !== e[31:0]) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, e[31:0]);
        end
    endtask
    task automatic complete_run;
        if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a == REG_CTRL) ctl <= d;
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] m, logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rq.push_back({m, v});
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    // lanes change every cycle; a taken word is noted as the design sees it
    always @(posedge clk) begin
        logic tk;
        tk = ctl[5:4] == 2'd0 ? t_sh : ctl[5:4] == 2'd1 ? t_tx : t_rx;
        if (rst_n && tk && lane_valid) begin
            if (!ctl[3] || !phase) wq.push_back({32'hffffffff, ctl[1] ?
                half(lane_hi, !ctl[0], ctl[2]) : 16'h0, half(lane_lo, !ctl[0], ctl[2])});
            phase <= ctl[3] & ~phase;
        end else if (!ctl[3]) phase <= 1'b0;
        st <= lfsr(st);
        lane_lo <= st[19:0];
        lane_hi <= ~st[31:12];
        lane_valid <= go & st[3];
    end
    always @(posedge clk) begin
        if (vld === 1'b1) check(rx_word, wq.size() ? wq.pop_front() : {32'hffffffff, 32'hx});
        if (rd_p) check(rdata, rq.pop_front());
        rd_p <= reg_rd;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(REG_CTRL, '1, CTRL_RESET);
        rd(REG_IRQ_MASK, '1, 32'h0);
        rd(4'hf, '1, 32'h0);
        for (int i = 0; i < 32; i++) begin
            wr(REG_CTRL, {26'h0, i[4:3], i[3:0]});
            slow <= i[0];
            go <= 1'b1;
            repeat (40) @(posedge clk);
            go <= 1'b0;
            repeat (4) @(posedge clk);
        end
        rd(REG_IRQ_STAT, 32'hf, 32'h7);
        wr(REG_IRQ_MASK, 32'h8);
        wr(REG_RECFG, 32'h105);
        wr(REG_RECFG, 32'h102);  // ignored while busy
        repeat (NW + 4) @(negedge clk);
        check({29'h0, msel}, {32'hffffffff, 32'h5});
        check({31'h0, irq}, {32'hffffffff, 32'h1});
        rd(REG_STATUS, 32'h3, 32'h2);
        rd(REG_RECFG, 32'h7, 32'h5);
        rd(REG_IRQ_STAT, 32'h8, 32'h8);
        rd(REG_IRQ_STAT, 32'h8, 32'h0);
        wr(REG_IRQ_MASK, 32'h0);
        wr(REG_RECFG, 32'h103);
        repeat (NW + 6) @(negedge clk);
        check({28'h0, msel, irq}, {32'hffffffff, 32'h6});
        repeat (3) @(posedge clk);
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule // rxwp_top_test
`default_nettype wire
